// ==== logic/cmt_defines.vh ====
`ifndef CMT_DEFINES_VH
`define CMT_DEFINES_VH

// Instance layout
`define CMT_NUM_TIMERS 4
`define CMT_NUM_WIDE 2
`define CMT_WIDE_BITS 32
`define CMT_NARROW_BITS 16
`define CMT_NUM_MATCH 4
`define CMT_NUM_CAP 2
`define CMT_NUM_FLAGS 6

// Flag positions within one instance
`define CMT_FLAG_MATCH0 0
`define CMT_FLAG_CAP0 4

// Count source select, two bits per instance
`define CMT_MODE_TIMER 2'h0
`define CMT_MODE_RISE 2'h1
`define CMT_MODE_FALL 2'h2
`define CMT_MODE_BOTH 2'h3

// Output action on match, two bits per match
`define CMT_ACT_NONE 2'h0
`define CMT_ACT_LOW 2'h1
`define CMT_ACT_HIGH 2'h2
`define CMT_ACT_TOGGLE 2'h3

// Reset values
`define CMT_COUNT_RST 32'h00000000
`define CMT_EXT_RST 1'h0

`endif

// ==== logic/cmt_edge.v ====
`timescale 1ns/1ps
`default_nettype none

module cmt_edge (
  // Clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // Sampled level
  input wire level_i,
  // Edge pulses
  output wire rise_o,
  output wire fall_o
);

  reg prev;

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev <= 1'h0;
    end else begin
      prev <= level_i;
    end
  end

  assign rise_o = level_i & ~prev;
  assign fall_o = ~level_i & prev;

endmodule // cmt_edge

`default_nettype wire

// ==== logic/cmt_match.v ====
`timescale 1ns/1ps
`default_nettype none
`include "cmt_defines.vh"

module cmt_match (
  // Clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // Compare inputs
  input wire [31:0] count_i,
  input wire [31:0] value_i,
  input wire [31:0] mask_i,
  input wire advance_i,
  input wire [1:0] action_i,
  // Results
  output wire hit_o,
  output reg ext_o
);

  // Only checked on the advancing cycle so a halted count does not re-fire
  assign hit_o = advance_i & (((count_i ^ value_i) & mask_i) == 32'h00000000);

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_o <= `CMT_EXT_RST;
    end else if (hit_o) begin
      case (action_i)
        `CMT_ACT_LOW: ext_o <= 1'h0;
        `CMT_ACT_HIGH: ext_o <= 1'h1;
        `CMT_ACT_TOGGLE: ext_o <= ~ext_o;
        default: ext_o <= ext_o;
      endcase
    end
  end

endmodule // cmt_match

`default_nettype wire

// ==== logic/cmt_quad.v ====
`timescale 1ns/1ps
`default_nettype none
`include "cmt_defines.vh"

module cmt_quad #(
  parameter NUM_WIDE = `CMT_NUM_WIDE,
  parameter NARROW_BITS = `CMT_NARROW_BITS
) (
  // Clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // Run control, one bit per instance
  input wire [3:0] run_i,
  input wire [3:0] hold_reset_i,
  // Count source, two mode bits and one pin select bit per instance
  input wire [7:0] mode_i,
  input wire [3:0] count_src_i,
  // Prescaler limits, 32 bits per instance
  input wire [127:0] prescale_limit_i,
  // Match values, 32 bits per match, four matches per instance
  input wire [511:0] match_value_i,
  // Match controls, one bit per match
  input wire [15:0] match_irq_en_i,
  input wire [15:0] match_reset_i,
  input wire [15:0] match_stop_i,
  // Match output actions, two bits per match
  input wire [31:0] ext_action_i,
  // Capture pins and controls, one bit per channel
  input wire [7:0] cap_pin_i,
  input wire [7:0] cap_rise_i,
  input wire [7:0] cap_fall_i,
  input wire [7:0] cap_irq_en_i,
  // Clear on capture, one bit per instance
  input wire [3:0] clear_en_i,
  input wire [3:0] clear_chan_i,
  input wire [3:0] clear_on_fall_i,
  // Flag clear pulses, six per instance
  input wire [23:0] flag_clear_i,
  // Counter state, 32 bits per instance, plus one halt bit per instance
  output wire [127:0] count_o,
  output wire [127:0] prescale_o,
  output wire [3:0] halted_o,
  // Capture values, 32 bits per channel
  output wire [255:0] cap_value_o,
  // Match outputs
  output wire [15:0] ext_o,
  // Interrupt flags and requests
  output wire [23:0] flags_o,
  output wire [3:0] irq_o
);

  // Narrow instances keep the upper half of every 32-bit slot at zero
  function [31:0] width_mask;
    input integer idx;
    begin
      if (idx < NUM_WIDE) begin
        width_mask = 32'hFFFFFFFF;
      end else begin
        width_mask = (32'h00000001 << NARROW_BITS) - 32'h00000001;
      end
    end
  endfunction

  genvar g;
  genvar m;

  generate
    for (g = 0; g < `CMT_NUM_TIMERS; g = g + 1) begin : g_tmr
      wire [31:0] mask;
      wire [31:0] limit;
      wire [1:0] mode;
      wire [1:0] rise;
      wire [1:0] fall;
      wire [1:0] cap_ev;
      wire [3:0] hit;
      wire src_rise;
      wire src_fall;
      wire count_ev;
      wire tick;
      wire pc_hit;
      wire advance;
      wire any_reset;
      wire any_stop;
      wire clear_ev;
      wire [`CMT_NUM_FLAGS-1:0] flag_set;
      reg [31:0] tc;
      reg [31:0] pc;
      reg halted;
      reg [31:0] cap0;
      reg [31:0] cap1;
      reg [`CMT_NUM_FLAGS-1:0] flags;

      assign mask = width_mask(g);
      assign limit = prescale_limit_i[g*32 +: 32] & mask;
      assign mode = mode_i[g*2 +: 2];

      cmt_edge u_edge0 (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .level_i(cap_pin_i[g*2]),
        .rise_o(rise[0]),
        .fall_o(fall[0])
      );

      cmt_edge u_edge1 (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .level_i(cap_pin_i[g*2+1]),
        .rise_o(rise[1]),
        .fall_o(fall[1])
      );

      // Counter mode takes its events from one of the two capture pins
      assign src_rise = count_src_i[g] ? rise[1] : rise[0];
      assign src_fall = count_src_i[g] ? fall[1] : fall[0];
      assign count_ev = (mode == `CMT_MODE_RISE) ? src_rise :
                        (mode == `CMT_MODE_FALL) ? src_fall :
                        (mode == `CMT_MODE_BOTH) ? (src_rise | src_fall) : 1'h1;

      // Timer mode ticks every system clock cycle
      assign tick = run_i[g] & ~halted & ~hold_reset_i[g] & count_ev;
      assign pc_hit = (pc == limit);
      assign advance = tick & pc_hit;

      for (m = 0; m < `CMT_NUM_MATCH; m = m + 1) begin : g_match
        cmt_match u_match (
          .core_clk_i(core_clk_i),
          .resetn_i(resetn_i),
          .count_i(tc),
          .value_i(match_value_i[(g*4+m)*32 +: 32]),
          .mask_i(mask),
          .advance_i(advance),
          .action_i(ext_action_i[(g*4+m)*2 +: 2]),
          .hit_o(hit[m]),
          .ext_o(ext_o[g*4+m])
        );
      end

      assign any_reset = |(hit & match_reset_i[g*4 +: 4]);
      assign any_stop = |(hit & match_stop_i[g*4 +: 4]);

      assign cap_ev[0] = (rise[0] & cap_rise_i[g*2]) | (fall[0] & cap_fall_i[g*2]);
      assign cap_ev[1] = (rise[1] & cap_rise_i[g*2+1]) | (fall[1] & cap_fall_i[g*2+1]);

      // Pair with capture on the opposite edge for pulse-width measurement
      assign clear_ev = clear_en_i[g] & (clear_on_fall_i[g] ?
                        fall[clear_chan_i[g]] : rise[clear_chan_i[g]]);

      // Counter and prescaler; a capture clear outranks a match reset
      always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          tc <= `CMT_COUNT_RST;
          pc <= `CMT_COUNT_RST;
        end else if (hold_reset_i[g] || clear_ev) begin
          tc <= `CMT_COUNT_RST;
          pc <= `CMT_COUNT_RST;
        end else if (tick) begin
          if (pc_hit) begin
            pc <= `CMT_COUNT_RST;
            if (any_reset) begin
              tc <= `CMT_COUNT_RST;
            end else begin
              tc <= (tc + 32'h00000001) & mask;
            end
          end else begin
            pc <= (pc + 32'h00000001) & mask;
          end
        end
      end

      // Halt stays until software drops the run bit
      always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          halted <= 1'h0;
        end else if (!run_i[g]) begin
          halted <= 1'h0;
        end else if (any_stop) begin
          halted <= 1'h1;
        end
      end

      // Snapshot is the count before any clear taken in the same cycle
      always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cap0 <= `CMT_COUNT_RST;
          cap1 <= `CMT_COUNT_RST;
        end else begin
          if (cap_ev[0]) begin
            cap0 <= tc;
          end
          if (cap_ev[1]) begin
            cap1 <= tc;
          end
        end
      end

      assign flag_set[`CMT_FLAG_MATCH0 +: 4] = hit & match_irq_en_i[g*4 +: 4];
      assign flag_set[`CMT_FLAG_CAP0 +: 2] = cap_ev & cap_irq_en_i[g*2 +: 2];

      // Set wins over a clear in the same cycle so no event is lost
      always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          flags <= 6'h00;
        end else begin
          flags <= (flags & ~flag_clear_i[g*6 +: 6]) | flag_set;
        end
      end

      assign count_o[g*32 +: 32] = tc;
      assign prescale_o[g*32 +: 32] = pc;
      assign halted_o[g] = halted;
      assign cap_value_o[g*64 +: 32] = cap0;
      assign cap_value_o[g*64+32 +: 32] = cap1;
      assign flags_o[g*6 +: 6] = flags;
      assign irq_o[g] = |flags;
    end
  endgenerate

endmodule // cmt_quad

`default_nettype wire

// ==== bench/cmt_quad_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmt_quad_assertions (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Controls
  input wire logic [3:0] run_i,
  input wire logic [3:0] hold_reset_i,
  input wire logic [7:0] mode_i,
  input wire logic [127:0] prescale_limit_i,
  input wire logic [511:0] match_value_i,
  input wire logic [15:0] match_reset_i,
  input wire logic [15:0] match_stop_i,
  input wire logic [31:0] ext_action_i,
  input wire logic [7:0] cap_pin_i,
  input wire logic [7:0] cap_rise_i,
  input wire logic [7:0] cap_irq_en_i,
  input wire logic [3:0] clear_en_i,
  // Observed
  input wire logic [127:0] count_o,
  input wire logic [127:0] prescale_o,
  input wire logic [3:0] halted_o,
  input wire logic [255:0] cap_value_o,
  input wire logic [15:0] ext_o,
  input wire logic [23:0] flags_o,
  input wire logic [3:0] irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Timer-mode tick with no clear or hold pending
  wire adv0 = run_i[0] && !halted_o[0] && !hold_reset_i[0] && !clear_en_i[0] && mode_i[1:0] == 2'h0;
  wire top0 = adv0 && prescale_o[31:0] == prescale_limit_i[31:0];
  wire hit01 = top0 && count_o[31:0] == match_value_i[63:32];
  wire adv1 = run_i[1] && !halted_o[1] && !hold_reset_i[1] && !clear_en_i[1] && mode_i[3:2] == 2'h0;
  wire hit14 = adv1 && prescale_o[63:32] == prescale_limit_i[63:32] && count_o[63:32] == match_value_i[159:128];
  a_prescale_wrap: assert property (top0 |=> prescale_o[31:0] == 32'h0) else $error("prescaler did not wrap");
  a_prescale_step: assert property (adv0 && prescale_o[31:0] < prescale_limit_i[31:0]
    |=> prescale_o[31:0] == $past(prescale_o[31:0]) + 32'h1) else $error("prescaler did not step");
  a_irq_merge: assert property (irq_o[3] == |flags_o[23:18]) else $error("irq not OR of flags");
  a_cap_value: assert property (cap_rise_i[7] && $rose(cap_pin_i[7])
    |=> cap_value_o[255:224] == $past(count_o[127:96])) else $error("capture value wrong");
  a_cap_flag: assert property (cap_irq_en_i[7] && cap_rise_i[7] && $rose(cap_pin_i[7])
    |=> flags_o[23]) else $error("capture flag missing");
  a_match_high: assert property (hit01 && ext_action_i[3:2] == 2'h2 |=> ext_o[1]) else $error("output not high");
  a_match_stop: assert property (hit01 && match_stop_i[1] |=> halted_o[0]) else $error("stop not taken");
  a_match_zero: assert property (hit14 && match_reset_i[4] |=> count_o[63:32] == 32'h0) else $error("no reset");
  c_stop: cover property (hit01 && match_stop_i[1]);
  c_reset: cover property (hit14);
  c_capture: cover property (flags_o[23]);
endmodule // cmt_quad_assertions

bind cmt_quad cmt_quad_assertions i_cmt_quad_assertions (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .run_i(run_i), .hold_reset_i(hold_reset_i),
  .mode_i(mode_i), .prescale_limit_i(prescale_limit_i), .match_value_i(match_value_i),
  .match_reset_i(match_reset_i), .match_stop_i(match_stop_i), .ext_action_i(ext_action_i),
  .cap_pin_i(cap_pin_i), .cap_rise_i(cap_rise_i), .cap_irq_en_i(cap_irq_en_i), .clear_en_i(clear_en_i),
  .count_o(count_o), .prescale_o(prescale_o), .halted_o(halted_o), .cap_value_o(cap_value_o),
  .ext_o(ext_o), .flags_o(flags_o), .irq_o(irq_o)
);
`default_nettype wire

// ==== bench/cmt_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmt_pins (
  // Clock
  input wire logic core_clk_i,
  // Capture signal sources, idle low as if pulled down
  output var logic [7:0] cap_pin_o
);
  initial cap_pin_o = 8'h00;
  // Levels change just after an edge so the block samples them a full cycle later
  task automatic pulse(input integer ch, input integer hi);
    @(posedge core_clk_i) cap_pin_o[ch] <= 1'b1;
    repeat (hi) @(posedge core_clk_i);
    cap_pin_o[ch] <= 1'b0;
  endtask
endmodule // cmt_pins
`default_nettype wire

// ==== bench/cmt_quad_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmt_quad_bench;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] run_i = 4'h0, hold_reset_i = 4'h0, count_src_i = 4'h0;
  logic [3:0] clear_en_i = 4'h4, clear_chan_i = 4'h0, clear_on_fall_i = 4'h0;
  logic [7:0] mode_i = 8'h40, cap_rise_i = 8'h80, cap_fall_i = 8'h10, cap_irq_en_i = 8'h80;
  // Instance 2 limit has only bit 16 set, so a 16-bit instance must cut it to zero
  logic [127:0] prescale_limit_i = {32'h0, 32'h00010000, 64'h2};
  logic [511:0] match_value_i = {352'h0, 32'h3, 64'h0, 32'h5, 32'h0};
  logic [15:0] match_irq_en_i = 16'h0010, match_reset_i = 16'h0010, match_stop_i = 16'h0002;
  logic [31:0] ext_action_i = 32'h00000308;
  logic [23:0] flag_clear_i = 24'h000000;
  wire [7:0] pins;
  wire [127:0] count_o, prescale_o;
  wire [255:0] cap_value_o;
  wire [15:0] ext_o;
  wire [23:0] flags_o;
  wire [3:0] halted_o, irq_o;
  integer bad_count = 0, checks_done = 0;

  cmt_pins i_cmt_pins (.core_clk_i(core_clk_i), .cap_pin_o(pins));
  cmt_quad i_cmt_quad (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .run_i(run_i),
    .hold_reset_i(hold_reset_i), .mode_i(mode_i), .count_src_i(count_src_i), .prescale_limit_i(prescale_limit_i),
    .match_value_i(match_value_i), .match_irq_en_i(match_irq_en_i), .match_reset_i(match_reset_i),
    .match_stop_i(match_stop_i), .ext_action_i(ext_action_i), .cap_pin_i(pins), .cap_rise_i(cap_rise_i),
    .cap_fall_i(cap_fall_i), .cap_irq_en_i(cap_irq_en_i), .clear_en_i(clear_en_i), .clear_chan_i(clear_chan_i),
    .clear_on_fall_i(clear_on_fall_i), .flag_clear_i(flag_clear_i), .count_o(count_o), .prescale_o(prescale_o),
    .halted_o(halted_o), .cap_value_o(cap_value_o), .ext_o(ext_o), .flags_o(flags_o), .irq_o(irq_o));

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Exactly n ticks: run is seen high from the next edge through the edge that lowers it
  task automatic run_for(input integer g, input integer n);
    @(posedge core_clk_i) run_i[g] <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    run_i[g] <= 1'b0;
    #1;
  endtask

  initial begin
    #200000;
    bad_count++;
    wrap_up;
  end

  initial begin
    repeat (4) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    run_for(0, 9);
    check("count0", count_o[31:0], 32'h00000003);
    check("pre0", prescale_o[31:0], 32'h00000000);
    @(posedge core_clk_i) hold_reset_i[0] <= 1'b1;
    @(posedge core_clk_i) hold_reset_i[0] <= 1'b0;
    run_for(0, 20);
    check("stop count", count_o[31:0], 32'h00000006);
    check("ext high", ext_o[1], 32'h1);
    check("halted", halted_o[0], 32'h1);
    @(posedge core_clk_i) begin
      hold_reset_i[0] <= 1'b1;
      ext_action_i[3:2] <= 2'h1;
    end
    @(posedge core_clk_i) hold_reset_i[0] <= 1'b0;
    run_for(0, 20);
    check("ext low", ext_o[1], 32'h0);
    run_for(1, 6);
    check("reset count", count_o[63:32], 32'h00000002);
    check("ext toggle", ext_o[4], 32'h1);
    check("match flag", flags_o[6], 32'h1);
    check("irq1", irq_o[1], 32'h1);
    @(posedge core_clk_i) run_i[3] <= 1'b1;
    repeat (3) i_cmt_pins.pulse(6, 2);
    @(posedge core_clk_i) #1;
    check("events", count_o[127:96], 32'h00000003);
    i_cmt_pins.pulse(7, 2);
    #1;
    check("cap value", cap_value_o[255:224], 32'h00000003);
    check("cap flag", flags_o[23], 32'h1);
    @(posedge core_clk_i) flag_clear_i[23] <= 1'b1;
    @(posedge core_clk_i) flag_clear_i[23] <= 1'b0;
    #1;
    check("flag cleared", flags_o[23], 32'h0);
    check("irq3", irq_o[3], 32'h0);
    // Falling edges of the second pin become the count source
    @(posedge core_clk_i) begin
      mode_i[7:6] <= 2'h2;
      count_src_i[3] <= 1'b1;
    end
    repeat (2) i_cmt_pins.pulse(7, 1);
    @(posedge core_clk_i) #1;
    check("fall events", count_o[127:96], 32'h00000005);
    @(posedge core_clk_i) run_i[2] <= 1'b1;
    i_cmt_pins.pulse(4, 10);
    @(posedge core_clk_i) #1;
    check("width", cap_value_o[159:128], 32'h00000009);
    check("narrow", count_o[95:80], 32'h0);
    wrap_up;
  end
endmodule // cmt_quad_bench
`default_nettype wire
